// ===== core/pdb_defs.svh
// register indices, field widths, reset values and bus codes of the dead-band stage
`ifndef PDB_DEFS_SVH
`define PDB_DEFS_SVH
`define PDB_ADDR_W        10
`define PDB_IDX_W         8
`define PDB_CTL_IDX       8'h1E
`define PDB_RISE_IDX      8'h20
`define PDB_FALL_IDX      8'h22
`define PDB_STAT_IDX      8'h23
`define PDB_LAG_W         10
`define PDB_LAG_MAX       10'h3FF
`define PDB_LAG_ZERO      10'h000
`define PDB_LAG_ONE       10'h001
`define PDB_CTL_W         6
`define PDB_CTL_RST       6'h00
`define PDB_OUT_MODE_BYP  2'h0
`define PDB_OUT_MODE_FALL 2'h1
`define PDB_OUT_MODE_RISE 2'h2
`define PDB_OUT_MODE_BOTH 2'h3
`define PDB_RESP_OKAY     2'h0
`define PDB_RESP_SLVERR   2'h2
`define PDB_ADDR_LSB_ZERO 2'h0
`define PDB_STAT_PAD      12'h000
`define PDB_CTL_PAD       10'h000
`define PDB_LAG_PAD       6'h00
`define PDB_RD_PAD        16'h0000
`endif

// ===== core/pdb_pkg.sv
// types shared by the dead-band stage modules
`include "pdb_defs.svh"
package pdb_pkg;
  typedef logic [`PDB_LAG_W-1:0] pdb_lag_t;
  // control fields, msb first: source select, inversion, output mode
  typedef struct packed {
    logic [1:0] source_select;
    logic [1:0] output_inversion_select;
    logic [1:0] out_mode;
  } pdb_ctl_s;
  typedef enum logic [1:0] {PDB_WR_IDLE = 2'b01, PDB_WR_RESP = 2'b10} pdb_wr_state_e;
  typedef enum logic [1:0] {PDB_RD_IDLE = 2'b01, PDB_RD_RESP = 2'b10} pdb_rd_state_e;
  typedef enum logic [2:0] {
    PDB_SEL_NONE, PDB_SEL_CTL, PDB_SEL_RISE, PDB_SEL_FALL, PDB_SEL_STAT
  } pdb_sel_e;
endpackage : pdb_pkg

// ===== core/pdb_lag_if.sv
// link between the control logic and one edge-lag path
`timescale 1ns/100ps
`default_nettype none
interface pdb_lag_if;
  import pdb_pkg::*;
  logic     src;
  pdb_lag_t edge_lag_count;
  logic     lagged;
  logic     busy;
  modport driver (output src, output edge_lag_count, input lagged, input busy);
  modport lagger (input src, input edge_lag_count, output lagged, output busy);
endinterface : pdb_lag_if
`default_nettype wire

// ===== core/pdb_edge_lag.sv
// one edge-lag path: delays the chosen edge of its source by a cycle count
`timescale 1ns/100ps
`default_nettype none
`include "pdb_defs.svh"
module pdb_edge_lag
  import pdb_pkg::*;
#(
  parameter bit LAG_FALLING = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  pdb_lag_if.lagger lag
);
  pdb_lag_t cnt_reg;
  pdb_lag_t cnt_next;
  logic     level;
  logic     held;

  // falling path works on the inverted source, same counting
  always_comb begin
    level    = LAG_FALLING ? ~lag.src : lag.src;
    held     = level && (cnt_reg >= lag.edge_lag_count);
    cnt_next = `PDB_LAG_ZERO;
    if (level) begin
      cnt_next = (cnt_reg == `PDB_LAG_MAX) ? cnt_reg : cnt_reg + `PDB_LAG_ONE;
    end
  end

  // falling path starts as if its source had been low for long
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= LAG_FALLING ? `PDB_LAG_MAX : `PDB_LAG_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign lag.lagged = LAG_FALLING ? ~held : held;
  assign lag.busy   = level && !held;
endmodule : pdb_edge_lag
`default_nettype wire

// ===== core/pdb_out_stage.sv
// output switch: inversion of lagged paths and bypass selection
`timescale 1ns/100ps
`default_nettype none
`include "pdb_defs.svh"
module pdb_out_stage
  import pdb_pkg::*;
(
  input  wire logic     [`PDB_CTL_W-1:0] ctl_bits,
  input  wire logic     aq_a,
  input  wire logic     aq_b,
  input  wire logic     rise_lagged,
  input  wire logic     fall_lagged,
  output logic          sel_a,
  output logic          sel_b
);
  pdb_ctl_s ctl;
  logic     rise_pol;
  logic     fall_pol;

  // inversion acts on lagged paths, bypass ignores it
  always_comb begin
    ctl      = pdb_ctl_s'(ctl_bits);
    rise_pol = rise_lagged ^ ctl.output_inversion_select[0];
    fall_pol = fall_lagged ^ ctl.output_inversion_select[1];
    sel_a    = aq_a;
    sel_b    = aq_b;
    unique case (ctl.out_mode)
      `PDB_OUT_MODE_BYP: begin
        sel_a = aq_a;
        sel_b = aq_b;
      end
      `PDB_OUT_MODE_FALL: begin
        sel_a = aq_a;
        sel_b = fall_pol;
      end
      `PDB_OUT_MODE_RISE: begin
        sel_a = rise_pol;
        sel_b = aq_b;
      end
      `PDB_OUT_MODE_BOTH: begin
        sel_a = rise_pol;
        sel_b = fall_pol;
      end
    endcase
  end
endmodule : pdb_out_stage
`default_nettype wire

// ===== core/pdb_deadband.sv
// dead-band stage top: register slave, source select, lag paths, output registers
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pdb_defs.svh"
module pdb_deadband
  import pdb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [`PDB_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`PDB_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   pwm_channel_a_in,
  input  wire logic                   pwm_channel_b_in,
  output logic                        pwm_channel_a_out,
  output logic                        pwm_channel_b_out
);

  // write side state
  pdb_wr_state_e          wr_state_reg;
  pdb_wr_state_e          wr_state_next;
  logic                   aw_got_reg;
  logic                   aw_got_next;
  logic                   w_got_reg;
  logic                   w_got_next;
  logic [`PDB_ADDR_W-1:0] waddr_reg;
  logic [`PDB_ADDR_W-1:0] waddr_next;
  logic [31:0]            wdata_reg;
  logic [31:0]            wdata_next;
  logic [3:0]             wstrb_reg;
  logic [3:0]             wstrb_next;
  logic [1:0]             bresp_reg;
  logic [1:0]             bresp_next;
  logic                   aw_take;
  logic                   w_take;
  logic                   wr_fire;
  pdb_sel_e               wr_sel;
  logic [`PDB_ADDR_W-1:0] eff_waddr;
  logic [31:0]            eff_wdata;
  logic [3:0]             eff_wstrb;

  // read side state
  pdb_rd_state_e          rd_state_reg;
  pdb_rd_state_e          rd_state_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  logic [1:0]             rresp_reg;
  logic [1:0]             rresp_next;
  logic                   ar_take;
  pdb_sel_e               rd_sel;

  // configuration registers
  pdb_ctl_s               deadband_control_reg;
  pdb_ctl_s               deadband_control_next;
  pdb_lag_t               rise_lag_amount_reg;
  pdb_lag_t               rise_lag_amount_next;
  pdb_lag_t               fall_lag_amount_reg;
  pdb_lag_t               fall_lag_amount_next;
  logic [15:0]            ctl_merged;
  logic [15:0]            rise_merged;
  logic [15:0]            fall_merged;

  // datapath
  logic                   chan_a_reg;
  logic                   chan_a_next;
  logic                   chan_b_reg;
  logic                   chan_b_next;
  logic                   sel_a;
  logic                   sel_b;
  logic [15:0]            status_word;

  pdb_lag_if rise_path ();
  pdb_lag_if fall_path ();

  // register select from a byte address; off-word addresses map nowhere
  function automatic pdb_sel_e pdb_decode(input logic [`PDB_ADDR_W-1:0] addr);
    logic [`PDB_IDX_W-1:0] idx;
    idx        = addr[`PDB_ADDR_W-1:2];
    pdb_decode = PDB_SEL_NONE;
    if (addr[1:0] == `PDB_ADDR_LSB_ZERO) begin
      unique case (idx)
        `PDB_CTL_IDX:  pdb_decode = PDB_SEL_CTL;
        `PDB_RISE_IDX: pdb_decode = PDB_SEL_RISE;
        `PDB_FALL_IDX: pdb_decode = PDB_SEL_FALL;
        `PDB_STAT_IDX: pdb_decode = PDB_SEL_STAT;
        default:       pdb_decode = PDB_SEL_NONE;
      endcase
    end
  endfunction : pdb_decode

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] pdb_merge(
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    pdb_merge = {strb[1] ? data[15:8] : old_val[15:8],
                 strb[0] ? data[7:0]  : old_val[7:0]};
  endfunction : pdb_merge

  // write address and data taken in either order
  assign s_axi_awready = (wr_state_reg == PDB_WR_IDLE) && !aw_got_reg;
  assign s_axi_wready  = (wr_state_reg == PDB_WR_IDLE) && !w_got_reg;
  assign s_axi_bvalid  = (wr_state_reg == PDB_WR_RESP);
  assign s_axi_bresp   = bresp_reg;

  // write channel next state
  always_comb begin
    aw_take       = s_axi_awvalid && s_axi_awready;
    w_take        = s_axi_wvalid && s_axi_wready;
    eff_waddr     = aw_take ? s_axi_awaddr : waddr_reg;
    eff_wdata     = w_take ? s_axi_wdata : wdata_reg;
    eff_wstrb     = w_take ? s_axi_wstrb : wstrb_reg;
    wr_sel        = pdb_decode(eff_waddr);
    waddr_next    = eff_waddr;
    wdata_next    = eff_wdata;
    wstrb_next    = eff_wstrb;
    aw_got_next   = aw_got_reg || aw_take;
    w_got_next    = w_got_reg || w_take;
    bresp_next    = bresp_reg;
    wr_state_next = wr_state_reg;
    wr_fire       = 1'b0;
    unique case (wr_state_reg)
      PDB_WR_IDLE: begin
        if (aw_got_next && w_got_next) begin
          wr_fire       = 1'b1;
          aw_got_next   = 1'b0;
          w_got_next    = 1'b0;
          bresp_next    = (wr_sel == PDB_SEL_NONE) ? `PDB_RESP_SLVERR : `PDB_RESP_OKAY;
          wr_state_next = PDB_WR_RESP;
        end
      end
      PDB_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = PDB_WR_IDLE;
        end
      end
      default: wr_state_next = PDB_WR_IDLE;
    endcase
  end

  // write channel registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_state_reg <= PDB_WR_IDLE;
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
      bresp_reg    <= `PDB_RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_got_reg   <= aw_got_next;
      w_got_reg    <= w_got_next;
      waddr_reg    <= waddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      bresp_reg    <= bresp_next;
    end
  end

  // register file next values; reserved bits never stored
  always_comb begin
    ctl_merged  = pdb_merge({`PDB_CTL_PAD, deadband_control_reg}, eff_wdata, eff_wstrb);
    rise_merged = pdb_merge({`PDB_LAG_PAD, rise_lag_amount_reg}, eff_wdata, eff_wstrb);
    fall_merged = pdb_merge({`PDB_LAG_PAD, fall_lag_amount_reg}, eff_wdata, eff_wstrb);
    deadband_control_next = deadband_control_reg;
    rise_lag_amount_next  = rise_lag_amount_reg;
    fall_lag_amount_next  = fall_lag_amount_reg;
    if (wr_fire) begin
      unique case (wr_sel)
        PDB_SEL_CTL:  deadband_control_next = pdb_ctl_s'(ctl_merged[`PDB_CTL_W-1:0]);
        PDB_SEL_RISE: rise_lag_amount_next  = rise_merged[`PDB_LAG_W-1:0];
        PDB_SEL_FALL: fall_lag_amount_next  = fall_merged[`PDB_LAG_W-1:0];
        PDB_SEL_STAT: deadband_control_next = deadband_control_reg;
        PDB_SEL_NONE: deadband_control_next = deadband_control_reg;
      endcase
    end
  end

  // register file; reset puts channel A on both paths, no inversion, bypass
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      deadband_control_reg <= pdb_ctl_s'(`PDB_CTL_RST);
      rise_lag_amount_reg  <= `PDB_LAG_ZERO;
      fall_lag_amount_reg  <= `PDB_LAG_ZERO;
    end else begin
      deadband_control_reg <= deadband_control_next;
      rise_lag_amount_reg  <= rise_lag_amount_next;
      fall_lag_amount_reg  <= fall_lag_amount_next;
    end
  end

  // live state: outputs and lag paths still counting
  assign status_word = {`PDB_STAT_PAD, fall_path.busy, rise_path.busy, chan_b_reg, chan_a_reg};

  // read channel handshakes
  assign s_axi_arready = (rd_state_reg == PDB_RD_IDLE);
  assign s_axi_rvalid  = (rd_state_reg == PDB_RD_RESP);
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // read channel next state; reserved bits come back zero
  always_comb begin
    ar_take       = s_axi_arvalid && s_axi_arready;
    rd_sel        = pdb_decode(s_axi_araddr);
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    rd_state_next = rd_state_reg;
    unique case (rd_state_reg)
      PDB_RD_IDLE: begin
        if (ar_take) begin
          rresp_next    = `PDB_RESP_OKAY;
          rd_state_next = PDB_RD_RESP;
          unique case (rd_sel)
            PDB_SEL_CTL:  rdata_next = {`PDB_RD_PAD, `PDB_CTL_PAD, deadband_control_reg};
            PDB_SEL_RISE: rdata_next = {`PDB_RD_PAD, `PDB_LAG_PAD, rise_lag_amount_reg};
            PDB_SEL_FALL: rdata_next = {`PDB_RD_PAD, `PDB_LAG_PAD, fall_lag_amount_reg};
            PDB_SEL_STAT: rdata_next = {`PDB_RD_PAD, status_word};
            PDB_SEL_NONE: begin
              rdata_next = '0;
              rresp_next = `PDB_RESP_SLVERR;
            end
          endcase
        end
      end
      PDB_RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_next = PDB_RD_IDLE;
        end
      end
      default: rd_state_next = PDB_RD_IDLE;
    endcase
  end

  // read channel registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_state_reg <= PDB_RD_IDLE;
      rdata_reg    <= '0;
      rresp_reg    <= `PDB_RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
    end
  end

  // source switches: bit 4 steers the rising path, bit 5 the falling path
  assign rise_path.src = deadband_control_reg.source_select[0] ? pwm_channel_b_in
                                                               : pwm_channel_a_in;
  assign fall_path.src = deadband_control_reg.source_select[1] ? pwm_channel_b_in
                                                               : pwm_channel_a_in;
  assign rise_path.edge_lag_count = rise_lag_amount_reg;
  assign fall_path.edge_lag_count = fall_lag_amount_reg;

  // rising-edge lag path
  pdb_edge_lag #(
    .LAG_FALLING (1'b0)
  ) u_rise_lag (
    .clk     (clk),
    .reset_n (reset_n),
    .lag     (rise_path)
  );

  // falling-edge lag path
  pdb_edge_lag #(
    .LAG_FALLING (1'b1)
  ) u_fall_lag (
    .clk     (clk),
    .reset_n (reset_n),
    .lag     (fall_path)
  );

  // inversion and bypass switches
  pdb_out_stage u_out_stage (
    .ctl_bits    (deadband_control_reg),
    .aq_a        (pwm_channel_a_in),
    .aq_b        (pwm_channel_b_in),
    .rise_lagged (rise_path.lagged),
    .fall_lagged (fall_path.lagged),
    .sel_a       (sel_a),
    .sel_b       (sel_b)
  );

  // output registers toward the chopper
  always_comb begin
    chan_a_next = sel_a;
    chan_b_next = sel_b;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chan_a_reg <= 1'b0;
      chan_b_reg <= 1'b0;
    end else begin
      chan_a_reg <= chan_a_next;
      chan_b_reg <= chan_b_next;
    end
  end

  assign pwm_channel_a_out = chan_a_reg;
  assign pwm_channel_b_out = chan_b_reg;

endmodule : pdb_deadband
`default_nettype wire

// ===== bench/pdb_deadband_asserts.sv
// port-level assertions for the dead-band stage
`timescale 1ns/100ps
`default_nettype none
`include "pdb_defs.svh"
module pdb_deadband_asserts (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [`PDB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [`PDB_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   pwm_channel_a_in,
  input wire logic                   pwm_channel_b_in,
  input wire logic                   pwm_channel_a_out,
  input wire logic                   pwm_channel_b_out
);
  localparam logic [9:0] CTL_A = {`PDB_CTL_IDX, `PDB_ADDR_LSB_ZERO};
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic       wr_hs;
  logic       ar_hs;
  logic       mapped;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // output mode as last written over the bus, for writes whose address and data handshake in the same cycle
  always_comb begin
    wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    ar_hs = s_axi_arvalid && s_axi_arready;
    mapped = s_axi_araddr inside {10'h078, 10'h080, 10'h088, 10'h08C};
    mode_next = mode_reg;
    if (wr_hs && s_axi_awaddr == CTL_A && s_axi_wstrb[0]) begin
      mode_next = s_axi_wdata[1:0];
    end
  end
  always_ff @(posedge clk) begin
    mode_reg <= reset_n ? mode_next : 2'h0;
  end
  property p_wr_answer;
    wr_hs |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write response dropped early");
  property p_wr_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("write taken during response");
  property p_rd_answer;
    ar_hs |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read response not held");
  property p_rd_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("read taken during response");
  property p_rd_unmapped;
    ar_hs && !mapped |=> s_axi_rresp == `PDB_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answer wrong");
  property p_rd_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:16] == `PDB_RD_PAD;
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("upper read bits set");
  property p_a_pass;
    !mode_reg[1] && !$past(mode_reg[1]) && !$past(mode_reg[1], 2) && $past(reset_n)
      |-> pwm_channel_a_out == $past(pwm_channel_a_in);
  endproperty
  a_a_pass: assert property (p_a_pass) else $error("channel a not passed");
  property p_b_pass;
    !mode_reg[0] && !$past(mode_reg[0]) && !$past(mode_reg[0], 2) && $past(reset_n)
      |-> pwm_channel_b_out == $past(pwm_channel_b_in);
  endproperty
  a_b_pass: assert property (p_b_pass) else $error("channel b not passed");
  c_both_lag: cover property (mode_reg == 2'h3 && pwm_channel_a_out);
  c_bypass: cover property (mode_reg == 2'h0 && pwm_channel_b_in);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `PDB_RESP_SLVERR);
endmodule : pdb_deadband_asserts
bind pdb_deadband pdb_deadband_asserts u_chk (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pwm_channel_a_in, .pwm_channel_b_in, .pwm_channel_a_out,
  .pwm_channel_b_out);
`default_nettype wire

// ===== bench/pdb_far_side.sv
// far-side model: action-qualifier pattern source
`timescale 1ns/100ps
`default_nettype none
module pdb_far_side (
  input  wire logic clk,
  input  wire logic run,
  output logic      a_reg,
  output logic      b_reg
);
  localparam logic [47:0] PAT_A = 48'hF0F3_8C1F_E07C;
  localparam logic [47:0] PAT_B = 48'h0FC3_3E0F_81F0;
  logic [5:0] step_reg;
  logic [5:0] step_next;
  // walk the pattern while running, rest low otherwise
  always_comb begin
    step_next = (run && step_reg != 6'h2F) ? step_reg + 6'h01 : 6'h00;
  end
  always_ff @(posedge clk) begin
    step_reg <= step_next;
    a_reg    <= run & PAT_A[step_reg];
    b_reg    <= run & PAT_B[step_reg];
  end
endmodule : pdb_far_side
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the dead-band stage
`timescale 1ns/100ps
`default_nettype none
`include "pdb_defs.svh"
module tb_top;
  import pdb_pkg::*;
  localparam logic [9:0] CTL_A  = {`PDB_CTL_IDX, `PDB_ADDR_LSB_ZERO};
  localparam logic [9:0] RISE_A = {`PDB_RISE_IDX, `PDB_ADDR_LSB_ZERO};
  localparam logic [9:0] FALL_A = {`PDB_FALL_IDX, `PDB_ADDR_LSB_ZERO};
  localparam logic [9:0] STAT_A = {`PDB_STAT_IDX, `PDB_ADDR_LSB_ZERO};
  logic        clk = 1'h0, reset_n = 1'h0, run = 1'h0, chk_on = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, a_in, b_in, a_out, b_out;
  logic        exp_a, exp_b;
  logic [5:0]  ctl_sh = 6'h00;
  int          rise_n, fall_n, hi_cnt, lo_cnt = 4096, err_count, checked;
  always #2.5 clk = ~clk;
  pdb_deadband u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_channel_a_in(a_in), .pwm_channel_b_in(b_in), .pwm_channel_a_out(a_out),
    .pwm_channel_b_out(b_out));
  pdb_far_side u_far (.clk(clk), .run(run), .a_reg(a_in), .b_reg(b_in));
  // expected outputs from the sampled inputs, one clock behind
  always @(posedge clk) begin
    logic rs, fs, rl, fl;
    rs = ctl_sh[4] ? b_in : a_in;
    fs = ctl_sh[5] ? b_in : a_in;
    rl = rs && hi_cnt >= rise_n;
    fl = fs || lo_cnt < fall_n;
    hi_cnt <= rs ? hi_cnt + 1 : 0;
    lo_cnt <= fs ? 0 : lo_cnt + 1;
    exp_a <= ctl_sh[1] ? rl ^ ctl_sh[2] : a_in;
    exp_b <= ctl_sh[0] ? fl ^ ctl_sh[3] : b_in;
  end
  // compare the chopper-side outputs with the model
  always @(negedge clk) begin
    if (chk_on) begin
      chk_bit("a_out", exp_a, a_out);
      chk_bit("b_out", exp_b, b_out);
    end
  end
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic bus_wr(input logic [9:0] ad, input logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid === 1'h1) && n < 200);
    bready <= 1'h0;
    rs = bresp;
    chk_bit("bvalid", 1'h1, bvalid);
  endtask : bus_wr
  task automatic bus_rd(input logic [9:0] ad, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= ad;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid === 1'h1) && n < 200);
    rready <= 1'h0;
    d = rdata;
    rs = rresp;
    chk_bit("rvalid", 1'h1, rvalid);
  endtask : bus_rd
  task automatic wr_chk(input logic [9:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] rs;
    bus_wr(ad, d, rs);
    chk_word("bresp", {30'h0, er}, {30'h0, rs});
  endtask : wr_chk
  task automatic rd_chk(input logic [9:0] ad, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  rs;
    bus_rd(ad, d, rs);
    chk_word("rdata", ed, d);
    chk_word("rresp", {30'h0, er}, {30'h0, rs});
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(CTL_A, 32'h0, `PDB_RESP_OKAY);
    rd_chk(RISE_A, 32'h0, `PDB_RESP_OKAY);
    rd_chk(FALL_A, 32'h0, `PDB_RESP_OKAY);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_regs;
    wr_chk(RISE_A, 32'hFFFF_FFFF, `PDB_RESP_OKAY);
    rd_chk(RISE_A, 32'h0000_03FF, `PDB_RESP_OKAY);
    wr_chk(FALL_A, 32'hFFFF_FFFF, `PDB_RESP_OKAY);
    rd_chk(FALL_A, 32'h0000_03FF, `PDB_RESP_OKAY);
    // upper lane only: bits 15:8 cleared, bits 7:0 kept
    wstrb <= 4'h2;
    wr_chk(RISE_A, 32'h0, `PDB_RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(RISE_A, 32'h0000_00FF, `PDB_RESP_OKAY);
    wr_chk(CTL_A, 32'hFFFF_FFFF, `PDB_RESP_OKAY);
    rd_chk(CTL_A, 32'h0000_003F, `PDB_RESP_OKAY);
    // status is read-only; idle inputs, both lagged paths inverted
    wr_chk(STAT_A, 32'hFFFF_FFFF, `PDB_RESP_OKAY);
    rd_chk(STAT_A, 32'h0000_0003, `PDB_RESP_OKAY);
    wr_chk(10'h090, 32'h0000_1234, `PDB_RESP_SLVERR);
    rd_chk(10'h090, 32'h0, `PDB_RESP_SLVERR);
    $display("test register access done");
  endtask : t_regs
  task automatic t_wave(input int r, input int f);
    wr_chk(RISE_A, 32'(r), `PDB_RESP_OKAY);
    wr_chk(FALL_A, 32'(f), `PDB_RESP_OKAY);
    rise_n = r;
    fall_n = f;
    for (int c = 0; c < 64; c++) begin
      chk_on = 1'h0;
      wr_chk(CTL_A, 32'(c), `PDB_RESP_OKAY);
      ctl_sh = 6'(c);
      repeat (12) @(posedge clk);
      chk_on = 1'h1;
      run <= 1'h1;
      repeat (48) @(posedge clk);
      run <= 1'h0;
      repeat (8) @(posedge clk);
    end
    chk_on = 1'h0;
    $display("test waveforms rise %0d fall %0d done", r, f);
  endtask : t_wave
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // watchdog against a hung handshake
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_wave(3, 5);
    t_wave(0, 1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
